// >>> pkg/feedback_pkg.sv
// Constants and types for the resolver / encoder feedback block
package feedback_pkg;
  // --------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_POLE = 8'h00;
  localparam logic [7:0] ADDR_RATIO = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_TONE = 8'h0c;
  localparam logic [7:0] ADDR_ANGLE = 8'h10;
  localparam logic [7:0] ADDR_MULTI = 8'h14;
  localparam logic [7:0] ADDR_ENCPOS = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  // --------------------------------------------------------------------
  // Reset values and limits
  // --------------------------------------------------------------------
  localparam logic [15:0] POLE_RESET = 16'h0002;
  localparam logic [15:0] POLE_MIN = 16'h0002;
  // Winding ratio in 1/256 units: 0.5, 0.22 and 1.34
  localparam logic [15:0] RATIO_RESET = 16'h0080;
  localparam logic [15:0] RATIO_MIN = 16'h0038;
  localparam logic [15:0] RATIO_MAX = 16'h0157;
  // Excitation level in 1/256 Vrms, limited to 10 Vrms
  localparam logic [15:0] LEVEL_MAX = 16'h0a00;
  localparam logic [15:0] TONE_RESET = 16'h0000;
  localparam logic [1:0] TONE_8K = 2'h0;
  localparam logic [1:0] TONE_4K = 2'h1;
  localparam logic [1:0] TONE_2K = 2'h2;
  // Tolerance allowed below the expected return vector length before a fault
  localparam logic [15:0] AMP_TOL = 16'h0400;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TONE_HZ = 8000;
  localparam int PHASE_STEPS = 64;
  localparam int STEP_CYC = CLK_HZ / (TONE_HZ * PHASE_STEPS);
  localparam logic [7:0] STEP_CYC_W = 8'(STEP_CYC);
  // --------------------------------------------------------------------
  // Status bits
  // --------------------------------------------------------------------
  localparam int ST_FAULT = 0;
  localparam int ST_WRAP = 1;
  localparam int ST_SAMPLE = 2;
  localparam int ST_W = 3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CORDIC = 3'b010,
    S_DONE = 3'b100
  } atan_state_t;
endpackage : feedback_pkg

// >>> logic/sine_rom.sv
// Registered quarter-wave sine table for the excitation tone
`timescale 1ns/1ns
module sine_rom #(
  parameter int AW = 6
) (
  input wire logic mclk,            // Clock
  input wire logic [AW-1:0] addr,   // Phase step
  output logic signed [11:0] rdata  // Registered sample
);
  logic signed [11:0] quarter;
  logic [AW-3:0] idx;
  // Second and fourth quarters read the table backwards
  always_comb begin
    idx = addr[AW-2] ? 4'(5'h10 - {1'b0, addr[AW-3:0]}) : addr[AW-3:0];
    case (idx)
      4'h0: quarter = addr[AW-2] ? 12'sh7ff : 12'sh000;
      4'h1: quarter = 12'sh0c8;
      4'h2: quarter = 12'sh18f;
      4'h3: quarter = 12'sh252;
      4'h4: quarter = 12'sh30f;
      4'h5: quarter = 12'sh3c5;
      4'h6: quarter = 12'sh471;
      4'h7: quarter = 12'sh513;
      4'h8: quarter = 12'sh5a8;
      4'h9: quarter = 12'sh62f;
      4'ha: quarter = 12'sh6a6;
      4'hb: quarter = 12'sh70e;
      4'hc: quarter = 12'sh764;
      4'hd: quarter = 12'sh7a8;
      4'he: quarter = 12'sh7d9;
      4'hf: quarter = 12'sh7f6;
      default: quarter = 12'sh000;
    endcase
  end
  always_ff @(posedge mclk) begin
    rdata <= addr[AW-1] ? -quarter : quarter;
  end
endmodule : sine_rom

// >>> logic/resolver_encoder_feedback.sv
// Resolver excitation, angle, multi-turn and quadrature encoder logic
`timescale 1ns/1ns
// Functional notes
// - The electrical angle is 16 bits and wraps at 65536 per cycle.
// - Angle wraps are counted into a signed 32-bit multi-turn position.
// - Tone select 0, 1, 2 gives 8, 4, 2 kHz excitation.
// - Pole setting is twice the pole pairs, at least and by default 2.
// - A sine excitation is driven and the angle is the arctangent.
// - 8 kHz is the tone used when nothing else is selected.
// - A return amplitude too far below ratio times level, or a ratio out of range, raises a fault.
// - Excitation level follows each ratio write and is limited to 10 Vrms.
// - Every edge of both quadrature channels moves the count, except A and B edges in the same cycle.
// - Channel B leading channel A is counter-clockwise.
// - Analogue encoder levels interpolate between quadrature counts.
// - Normally A leading B counts positive (clockwise).
module resolver_encoder_feedback (
  input wire logic mclk,                  // 25 MHz clock
  input wire logic rst_n,                 // Synchronous reset
  input wire logic [7:0] s_axi_awaddr,    // Write address
  input wire logic s_axi_awvalid,         // Write address valid
  output logic s_axi_awready,             // Write address ready
  input wire logic [31:0] s_axi_wdata,    // Write data
  input wire logic [3:0] s_axi_wstrb,     // Write strobes
  input wire logic s_axi_wvalid,          // Write data valid
  output logic s_axi_wready,              // Write data ready
  output logic [1:0] s_axi_bresp,         // Write response
  output logic s_axi_bvalid,              // Write response valid
  input wire logic s_axi_bready,          // Write response ready
  input wire logic [7:0] s_axi_araddr,    // Read address
  input wire logic s_axi_arvalid,         // Read address valid
  output logic s_axi_arready,             // Read address ready
  output logic [31:0] s_axi_rdata,        // Read data
  output logic [1:0] s_axi_rresp,         // Read response
  output logic s_axi_rvalid,              // Read data valid
  input wire logic s_axi_rready,          // Read data ready
  output logic signed [11:0] excitationOutputPair, // Excitation sample
  input wire logic signed [11:0] sineInputPair,    // Sine return sample
  input wire logic signed [11:0] cosineInputPair,  // Cosine return sample
  input wire logic encA,                  // Quadrature channel A pin
  input wire logic encB,                  // Quadrature channel B pin
  input wire logic signed [11:0] encSin,  // Analogue encoder sine
  input wire logic signed [11:0] encCos,  // Analogue encoder cosine
  output logic irq                        // Interrupt level
);
  import feedback_pkg::*;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [15:0] pole_reg, pole_next, ratio_reg, ratio_next;
  logic [15:0] level_reg, level_next, tone_reg, tone_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [ST_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [15:0] angle_reg, angle_next;
  logic signed [31:0] multi_reg, multi_next, encCnt_reg, encCnt_next;
  logic [9:0] interp_reg, interp_next;
  logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [7:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic faultEv, wrapEv, sampleEv;

  // 16-bit fields of a write, honouring byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  logic doWrite, doRead, wrOk, rdOk;
  logic [15:0] wv;
  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    pole_next = pole_reg;
    ratio_next = ratio_reg;
    level_next = level_reg;
    tone_next = tone_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    wrOk = 1'b1;
    rdOk = 1'b1;
    wv = 16'h0000;
    if (s_axi_awvalid && !awHeld_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bvalid_next = 1'b1;
      case (awAddr_reg)
        ADDR_POLE: begin
          wv = merge16(pole_reg, wData_reg, wStrb_reg);
          pole_next = (wv < POLE_MIN) ? POLE_MIN : wv;
        end
        ADDR_RATIO: begin
          ratio_next = merge16(ratio_reg, wData_reg, wStrb_reg);
          wv = 16'(({16'h0000, ratio_next} * 32'd20) >> 2);
          level_next = (wv > LEVEL_MAX) ? LEVEL_MAX : wv;
        end
        ADDR_LEVEL: begin
          wv = merge16(level_reg, wData_reg, wStrb_reg);
          level_next = (wv > LEVEL_MAX) ? LEVEL_MAX : wv;
        end
        ADDR_TONE: begin
          wv = merge16(tone_reg, wData_reg, wStrb_reg);
          tone_next = (wv > 16'(TONE_2K)) ? tone_reg : wv;
        end
        ADDR_CTRL: if (wStrb_reg[0]) ctrl_next = wData_reg[1:0];
        ADDR_MASK: if (wStrb_reg[0]) mask_next = wData_reg[ST_W-1:0];
        default: wrOk = 1'b0;
      endcase
      bresp_next = wrOk ? 2'h0 : 2'h2;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    doRead = s_axi_arvalid && !rvalid_reg;
    if (doRead) begin
      rvalid_next = 1'b1;
      case (s_axi_araddr)
        ADDR_POLE: rdata_next = {16'h0000, pole_reg};
        ADDR_RATIO: rdata_next = {16'h0000, ratio_reg};
        ADDR_LEVEL: rdata_next = {16'h0000, level_reg};
        ADDR_TONE: rdata_next = {16'h0000, tone_reg};
        ADDR_ANGLE: rdata_next = {16'h0000, angle_reg};
        ADDR_MULTI: rdata_next = multi_reg;
        ADDR_ENCPOS: rdata_next = encCnt_reg;
        ADDR_CTRL: rdata_next = {20'h0, interp_reg, ctrl_reg};
        ADDR_STATUS: rdata_next = {29'h0, status_reg};
        ADDR_MASK: rdata_next = {29'h0, mask_reg};
        default: begin
          rdata_next = 32'h0;
          rdOk = 1'b0;
        end
      endcase
      rresp_next = rdOk ? 2'h0 : 2'h2;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Excitation tone
  // ------------------------------------------------------------------
  logic [7:0] div_reg, div_next;
  logic [7:0] phase_reg, phase_next;
  logic stepEn;
  logic signed [11:0] romOut;
  always_comb begin
    stepEn = (div_reg == STEP_CYC_W - 8'h01);
    div_next = stepEn ? 8'h00 : div_reg + 8'h01;
    phase_next = phase_reg;
    if (stepEn) begin
      case (tone_reg[1:0])
        TONE_4K: phase_next = phase_reg + 8'h01;
        TONE_2K: phase_next = phase_reg + 8'h01;
        default: phase_next = phase_reg + 8'h02;
      endcase
    end
  end
  // 8 kHz steps the phase twice as fast; 2 kHz uses the slower divider bit
  logic [5:0] romAddr;
  assign romAddr = (tone_reg[1:0] == TONE_2K) ? phase_reg[7:2] :
                   phase_reg[6:1];
  sine_rom #(.AW(6)) u_rom (
    .mclk(mclk),
    .addr(romAddr),
    .rdata(romOut)
  );
  logic signed [11:0] excit_reg, excit_next;
  always_comb begin
    excit_next = 12'(({{12{romOut[11]}}, romOut} *
                      $signed({12'h0, level_reg[11:0]})) >>> 12);
  end

  // ------------------------------------------------------------------
  // Demodulation and CORDIC arctangent
  // ------------------------------------------------------------------
  logic peak;
  assign peak = stepEn && (romAddr == 6'h10);
  atan_state_t st_reg, st_next;
  logic signed [17:0] cx_reg, cx_next, cy_reg, cy_next;
  logic [15:0] cz_reg, cz_next;
  logic [3:0] it_reg, it_next;
  logic [15:0] amp;
  function automatic logic [15:0] atanTab(input logic [3:0] i);
    case (i)
      4'h0: atanTab = 16'h2000;
      4'h1: atanTab = 16'h12e4;
      4'h2: atanTab = 16'h09fb;
      4'h3: atanTab = 16'h0511;
      4'h4: atanTab = 16'h028b;
      4'h5: atanTab = 16'h0146;
      4'h6: atanTab = 16'h00a3;
      4'h7: atanTab = 16'h0051;
      4'h8: atanTab = 16'h0029;
      4'h9: atanTab = 16'h0014;
      4'ha: atanTab = 16'h000a;
      4'hb: atanTab = 16'h0005;
      4'hc: atanTab = 16'h0003;
      default: atanTab = 16'h0001;
    endcase
  endfunction : atanTab
  always_comb begin
    st_next = st_reg;
    cx_next = cx_reg;
    cy_next = cy_reg;
    cz_next = cz_reg;
    it_next = it_reg;
    angle_next = angle_reg;
    multi_next = multi_reg;
    sampleEv = 1'b0;
    wrapEv = 1'b0;
    faultEv = 1'b0;
    amp = 16'h0;
    case (st_reg)
      S_IDLE: if (peak) begin
        // Pre-rotate into the right half plane
        if (cosineInputPair < 0) begin
          cx_next = -18'(cosineInputPair);
          cy_next = -18'(sineInputPair);
          cz_next = 16'h8000;
        end else begin
          cx_next = 18'(cosineInputPair);
          cy_next = 18'(sineInputPair);
          cz_next = 16'h0000;
        end
        it_next = 4'h0;
        st_next = S_CORDIC;
      end
      S_CORDIC: begin
        if (cy_reg < 0) begin
          cx_next = cx_reg - (cy_reg >>> it_reg);
          cy_next = cy_reg + (cx_reg >>> it_reg);
          cz_next = cz_reg - atanTab(it_reg);
        end else begin
          cx_next = cx_reg + (cy_reg >>> it_reg);
          cy_next = cy_reg - (cx_reg >>> it_reg);
          cz_next = cz_reg + atanTab(it_reg);
        end
        it_next = it_reg + 4'h1;
        if (it_reg == 4'hd) st_next = S_DONE;
      end
      S_DONE: begin
        angle_next = cz_reg;
        multi_next = {multi_reg[31:16], cz_reg};
        sampleEv = 1'b1;
        // Wrap when the angle crosses between the last and the first quarter of a cycle
        if (angle_reg[15:14] == 2'b11 && cz_reg[15:14] == 2'b00) begin
          multi_next = {multi_reg[31:16] + 16'h0001, cz_reg};
          wrapEv = 1'b1;
        end else if (angle_reg[15:14] == 2'b00 && cz_reg[15:14] == 2'b11)
        begin
          multi_next = {multi_reg[31:16] - 16'h0001, cz_reg};
          wrapEv = 1'b1;
        end
        // Vector length (gain 1.647) against ratio times level
        amp = 16'(({14'h0, cx_reg} * 32'd159) >> 8);
        if (amp + AMP_TOL < 16'(({16'h0, ratio_reg} * {16'h0, level_reg})
            >> 12) || ratio_reg < RATIO_MIN || ratio_reg > RATIO_MAX)
          faultEv = 1'b1;
        st_next = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // Quadrature counter with interpolation
  // ------------------------------------------------------------------
  logic [1:0] aSync_reg, bSync_reg, aSync_next, bSync_next;
  logic aOld_reg, bOld_reg;
  logic up, dn;
  always_comb begin
    aSync_next = {aSync_reg[0], encA};
    bSync_next = {bSync_reg[0], encB};
    // A leads B: A toggles to differ from B, counted positive
    up = (aSync_reg[1] != aOld_reg && aSync_reg[1] != bSync_reg[1]) ||
         (bSync_reg[1] != bOld_reg && bSync_reg[1] == aSync_reg[1]);
    dn = (aSync_reg[1] != aOld_reg && aSync_reg[1] == bSync_reg[1]) ||
         (bSync_reg[1] != bOld_reg && bSync_reg[1] != aSync_reg[1]);
    if (ctrl_reg[0]) begin // reversed: B leading A counts positive
      {up, dn} = {dn, up};
    end
    encCnt_next = encCnt_reg;
    if (up && !dn) encCnt_next = encCnt_reg + 32'sd1;
    else if (dn && !up) encCnt_next = encCnt_reg - 32'sd1;
    // Fraction within a count from the analogue octant
    interp_next = ctrl_reg[1] ? 10'({encSin[11] ^ encCos[11],
        (encSin[11] ? -encSin[10:2] : encSin[10:2])}) : 10'h0;
    status_next = status_reg | {sampleEv, wrapEv, faultEv};
    if (doRead && s_axi_araddr == ADDR_STATUS)
      status_next = {sampleEv, wrapEv, faultEv};
    irq_next = |(status_next & mask_reg);
  end

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pole_reg <= POLE_RESET;
      ratio_reg <= RATIO_RESET;
      level_reg <= 16'h0000;
      tone_reg <= TONE_RESET;
      ctrl_reg <= 2'h0;
      mask_reg <= '0;
      status_reg <= '0;
      angle_reg <= 16'h0000;
      multi_reg <= 32'sd0;
      encCnt_reg <= 32'sd0;
      interp_reg <= 10'h0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0;
      irq_reg <= 1'b0;
      div_reg <= 8'h0;
      phase_reg <= 8'h0;
      excit_reg <= 12'sh0;
      st_reg <= S_IDLE;
      cx_reg <= 18'sh0;
      cy_reg <= 18'sh0;
      cz_reg <= 16'h0;
      it_reg <= 4'h0;
      aSync_reg <= 2'h0;
      bSync_reg <= 2'h0;
      aOld_reg <= 1'b0;
      bOld_reg <= 1'b0;
    end else begin
      pole_reg <= pole_next;
      ratio_reg <= ratio_next;
      level_reg <= level_next;
      tone_reg <= tone_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      angle_reg <= angle_next;
      multi_reg <= multi_next;
      encCnt_reg <= encCnt_next;
      interp_reg <= interp_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      div_reg <= div_next;
      phase_reg <= phase_next;
      excit_reg <= excit_next;
      st_reg <= st_next;
      cx_reg <= cx_next;
      cy_reg <= cy_next;
      cz_reg <= cz_next;
      it_reg <= it_next;
      aSync_reg <= aSync_next;
      bSync_reg <= bSync_next;
      aOld_reg <= aSync_reg[1];
      bOld_reg <= bSync_reg[1];
    end
  end

  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready = !wHeld_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign excitationOutputPair = excit_reg;
  assign irq = irq_reg;
endmodule : resolver_encoder_feedback

// >>> test/shaft_sensor_model.sv
// Behavioural resolver and quadrature encoder on the motor shaft
`timescale 1ns/1ns
module shaft_sensor_model (
  input wire logic mclk, // Clock
  input wire logic signed [11:0] excitationOutputPair, // Excitation
  output logic signed [11:0] sineInputPair = 12'sh000, // Sine return
  output logic signed [11:0] cosineInputPair = 12'sh000, // Cosine return
  output logic encA, // Channel A
  output logic encB, // Channel B
  output logic signed [11:0] encSin, // Analogue sine
  output logic signed [11:0] encCos // Analogue cosine
);
  real theta = 0.0;
  real gain = 0.5;
  logic [1:0] phase = 2'h0;
  // Returns carry the excitation scaled by the shaft angle
  always @(posedge mclk) begin
    sineInputPair <= 12'($rtoi(excitationOutputPair * gain * $sin(theta)));
    cosineInputPair <= 12'($rtoi(excitationOutputPair * gain * $cos(theta)));
  end
  // Gray sequence: rising phase means A leads B
  assign encA = phase[1] ^ phase[0];
  assign encB = phase[1];
  assign encSin = encA ? 12'sh258 : -12'sh258;
  assign encCos = encB ? 12'sh258 : -12'sh258;
  task automatic turn(input int dir, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (10) @(posedge mclk);
      phase <= phase + 2'(dir);
    end
    repeat (6) @(posedge mclk);
  endtask : turn
endmodule : shaft_sensor_model

// >>> test/feedback_sva.sv
// Bus, reset and excitation checks for the feedback block
`timescale 1ns/1ns
module feedback_sva (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [7:0] s_axi_araddr, // AR addr
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic signed [11:0] excitationOutputPair, // Excitation
  input wire logic irq // Interrupt
);
  logic signed [11:0] excPrev_reg;
  logic [15:0] excCnt_reg, excCnt_next;
  // Cycles a nonzero excitation sample has stood still
  always_comb begin
    excCnt_next = excCnt_reg + 16'h0001;
    if (!rst_n || excitationOutputPair != excPrev_reg) excCnt_next = 16'h0;
    if (excitationOutputPair == 12'sh000) excCnt_next = 16'h0;
  end
  always_ff @(posedge mclk) begin
    excPrev_reg <= excitationOutputPair;
    excCnt_reg <= excCnt_next;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bresp lost");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rdata lost");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read data");
  property p_read_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h24 |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("bad rresp");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[1:3] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no bvalid");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("extra bvalid");
  property p_reset_quiet;
    disable iff (1'b0) !rst_n |=> !irq && !s_axi_bvalid && !s_axi_rvalid &&
      excitationOutputPair == 12'sh000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("reset");
  property p_exc_moves;
    excCnt_reg < 16'd1000;
  endproperty
  a_exc_moves: assert property (p_exc_moves)
    else $error("tone stuck");
  c_irq: cover property ($rose(irq));
  c_rerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : feedback_sva
bind resolver_encoder_feedback feedback_sva chk_u (.mclk(mclk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .excitationOutputPair(excitationOutputPair), .irq(irq));

// >>> test/resolver_encoder_feedback_bench.sv
// Self-checking bench for the resolver / encoder feedback block
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module resolver_encoder_feedback_bench;
  import feedback_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, irq;
  logic awready, wready, bvalid, arready, rvalid, encA, encB;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic [1:0] bresp, rresp, resp;
  logic signed [11:0] exc, sinRet, cosRet, encSin, encCos;
  int n_mismatch = 0, checks_done = 0, p;
  always #20 mclk = ~mclk;
  resolver_encoder_feedback dut_u (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .excitationOutputPair(exc),
    .sineInputPair(sinRet), .cosineInputPair(cosRet), .encA(encA),
    .encB(encB), .encSin(encSin), .encCos(encCos), .irq(irq));
  shaft_sensor_model sensor_u (.mclk(mclk), .excitationOutputPair(exc),
    .sineInputPair(sinRet), .cosineInputPair(cosRet), .encA(encA),
    .encB(encB), .encSin(encSin), .encCos(encCos));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp; bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdat = rdata; resp = rresp; rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  function automatic logic near(input logic [15:0] v, input logic [15:0] e);
    logic [15:0] d;
    d = v - e;
    return d < 16'd400 || d > 16'd65136;
  endfunction : near
  task automatic t_regs();
    rd(ADDR_POLE); `CHK(rdat, 32'h2)
    rd(ADDR_TONE); `CHK(rdat, 32'h0)
    rd(ADDR_MULTI); `CHK(rdat, 32'h0)
    rd(ADDR_ENCPOS); `CHK(rdat, 32'h0)
    wr(ADDR_POLE, 32'h1); rd(ADDR_POLE); `CHK(rdat, 32'h2)
    wr(ADDR_POLE, 32'h8); rd(ADDR_POLE); `CHK(rdat, 32'h8)
    wr(ADDR_LEVEL, 32'hffff); rd(ADDR_LEVEL);
    `CHK(rdat, {16'h0, LEVEL_MAX})
    wr(ADDR_POLE, 32'h2); rd(8'h30); `CHK({resp, rdat}, 34'h200000000)
    wr(8'h40, 32'h5); `CHK(resp, 2'h2)
  endtask : t_regs
  task automatic t_enc();
    sensor_u.turn(1, 8); rd(ADDR_ENCPOS); `CHK(rdat, 32'h8)
    sensor_u.turn(-1, 3); rd(ADDR_ENCPOS); `CHK(rdat, 32'h5)
    wr(ADDR_CTRL, 32'h1); sensor_u.turn(1, 2); rd(ADDR_ENCPOS);
    `CHK(rdat, 32'h3)
    wr(ADDR_CTRL, 32'h2); rd(ADDR_CTRL);
    `CHK(rdat[11:2] != 10'h0, 1'b1)
    wr(ADDR_CTRL, 32'h0); rd(ADDR_CTRL); `CHK(rdat, 32'h0)
  endtask : t_enc
  task automatic settle(input real deg);
    sensor_u.theta <= deg * 3.14159265 / 180.0;
    repeat (7000) @(posedge mclk);
  endtask : settle
  task automatic t_res();
    wr(ADDR_RATIO, 32'h80);
    settle(90.0); rd(ADDR_ANGLE);
    `CHK(near(rdat[15:0], 16'd16384), 1'b1)
    settle(300.0); settle(30.0); rd(ADDR_MULTI);
    `CHK(rdat[31:16], 16'h0001)
    settle(300.0); rd(ADDR_MULTI); `CHK(rdat[31:16], 16'h0000)
  endtask : t_res
  task automatic t_irq();
    wr(ADDR_MASK, 32'h0); repeat (4000) @(posedge mclk); `CHK(irq, 1'b0)
    rd(ADDR_STATUS); `CHK(rdat[0], 1'b0)
    wr(ADDR_RATIO, 32'h10); repeat (4000) @(posedge mclk);
    wr(ADDR_MASK, 32'h4); repeat (3) @(posedge mclk); `CHK(irq, 1'b1)
    rd(ADDR_STATUS); `CHK(rdat[2:0], 3'h5)
    repeat (3) @(posedge mclk); `CHK(irq, 1'b0)
    wr(ADDR_RATIO, 32'h80);
  endtask : t_irq
  task automatic period(output int n);
    logic signed [11:0] prev;
    for (int c = 0; c < 2; c++) begin
      n = 0;
      do begin
        prev = exc; @(posedge mclk); n++;
      end while (!(prev < 0 && exc >= 0));
    end
  endtask : period
  task automatic t_tone();
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_TONE, 32'(c)); period(p);
      `CHK(p > (3000 << c) && p < (3250 << c), 1'b1)
    end
    wr(ADDR_TONE, 32'h3); rd(ADDR_TONE); `CHK(rdat, 32'h2)
  endtask : t_tone
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs(); t_enc(); t_res(); t_irq(); t_tone();
    print_verdict();
  end
  initial begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule : resolver_encoder_feedback_bench
